// *** shared/psf_defs.vh ***
// constants for the processing state, privilege and space code block
`ifndef PSF_DEFS_VH
`define PSF_DEFS_VH

// processing states
`define PSF_ST_RST_SP    3'h0
`define PSF_ST_RST_PC    3'h1
`define PSF_ST_NORMAL    3'h2
`define PSF_ST_STOPPED   3'h3
`define PSF_ST_EXC_PUSH  3'h4
`define PSF_ST_EXC_VEC   3'h5
`define PSF_ST_EXC_FILL  3'h6
`define PSF_ST_HALTED    3'h7

// space code values
`define PSF_FC_USER_DATA 3'h1
`define PSF_FC_USER_PROG 3'h2
`define PSF_FC_SUP_DATA  3'h5
`define PSF_FC_SUP_PROG  3'h6
`define PSF_FC_CPU       3'h7

// status word layout and reset value
`define PSF_SW_S_BIT     13
`define PSF_SW_RESET     16'h2700

// reset vector locations
`define PSF_RST_SP_ADDR  32'h00000000
`define PSF_RST_PC_ADDR  32'h00000004

// special cycle field positions
`define PSF_CTYPE_LSB    16
`define PSF_CTYPE_MSB    19
`define PSF_LEVEL_LSB    1
`define PSF_LEVEL_MSB    4

`endif

// *** src/psf_ctrl.v ***
// processing state, privilege level and bus space code control
//
// Overview of operation
// - stop instructions enter stopped state, no bus cycles
// - stopped resumes only on trace, interrupt, reset
// - bus or address error during exception halts
// - supervisor flag selects privilege and stack pointer
// - supervisor level drives supervisor space codes
// - exception processing is supervisor, uses supervisor stack
// - user level refuses privileged instructions as violations
// - user level stack references use user pointer
// - push status word first, then set supervisor
// - status writes and return flush the pipeline
// - short frame return restores status and counter
// - error frame return restores whole saved state
// - three-bit space code names eight spaces
// - program versus data, supervisor versus user automatic
// - special cycles use their own cpu space code
// - reset fetches stack pointer from zero, counter from four
// - exception covers pushes, vector, refill until handler
// - no-op waits until earlier instructions complete
// - cpu space cycle type on address 19..16
// - acknowledged interrupt level on address 4..1
`timescale 1ns/10ps
`default_nettype none
`include "psf_defs.vh"

module psf_ctrl (
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        reset_i,
    // instruction events from the decoder, one-cycle pulses
    input  wire        stop_instr_i,
    input  wire        low_power_stop_instr_i,
    input  wire        reset_instr_i,
    input  wire        status_word_wr_i,
    input  wire [15:0] status_word_wdata_i,
    input  wire        return_from_exception_i,
    input  wire        rte_long_frame_i,
    input  wire [15:0] rte_status_i,
    input  wire [31:0] rte_pc_i,
    input  wire        nop_instr_i,
    input  wire        pipe_idle_i,
    // exception sources
    input  wire        exc_req_i,
    input  wire        exc_trace_i,
    input  wire        exc_irq_i,
    input  wire [31:0] exc_vec_addr_i,
    input  wire        fill_done_i,
    input  wire        bus_err_i,
    input  wire        addr_err_i,
    // core bus requests
    input  wire        core_req_i,
    input  wire        core_prog_i,
    input  wire        core_cpu_i,
    input  wire [3:0]  core_ctype_i,
    input  wire [3:0]  core_level_i,
    input  wire [31:0] core_addr_i,
    // stack pointer access
    input  wire        sp_wr_i,
    input  wire [31:0] sp_wdata_i,
    // bus side
    input  wire        bus_ack_i,
    input  wire [31:0] bus_rdata_i,
    output wire        bus_req_o,
    output reg  [2:0]  space_code_lines_o,
    output reg  [31:0] bus_addr_o,
    output reg  [31:0] bus_wdata_o,
    output reg         bus_write_o,
    // state and control outputs
    output reg  [2:0]  proc_state_o,
    output reg  [15:0] status_word_o,
    output reg  [31:0] pc_o,
    output wire        supervisor_o,
    output wire [31:0] address_reg_seven_o,
    output reg         priv_viol_o,
    output reg         flush_o,
    output reg         full_restore_o,
    output wire        nop_go_o
);

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [15:0] status_word;
    reg  [15:0] saved_status;
    reg  [31:0] user_stack_pointer;
    reg  [31:0] sup_stack_pointer;
    reg  [31:0] pc;

    wire        in_exc;
    wire        sup_eff;
    wire        priv_instr;
    wire        bus_fault;
    wire        exc_any;
    wire        stop_any;

    // space code from privilege, access kind and special cycles
    function [2:0] space_code;
        input sup;
        input prog;
        input cpu;
        begin
            if (cpu) begin
                space_code = `PSF_FC_CPU;
            end else if (sup) begin
                space_code = prog ? `PSF_FC_SUP_PROG : `PSF_FC_SUP_DATA;
            end else begin
                space_code = prog ? `PSF_FC_USER_PROG : `PSF_FC_USER_DATA;
            end
        end
    endfunction

    assign in_exc = (state == `PSF_ST_EXC_PUSH) || (state == `PSF_ST_EXC_VEC)
                 || (state == `PSF_ST_EXC_FILL);
    // exception work is supervisor even before the flag is set
    assign sup_eff = status_word[`PSF_SW_S_BIT] || in_exc;
    assign supervisor_o = sup_eff;
    // user level sees the user pointer for both implicit and explicit use
    assign address_reg_seven_o = sup_eff ? sup_stack_pointer : user_stack_pointer;
    // status writes and returns can change the flag, so both are privileged
    assign priv_instr = stop_instr_i || low_power_stop_instr_i || reset_instr_i
                     || status_word_wr_i || return_from_exception_i;
    assign bus_fault = bus_err_i || addr_err_i;
    // any exception source; it wins over an instruction in the same cycle
    assign exc_any = exc_req_i || exc_trace_i || exc_irq_i;
    // both stop flavours act alike here; only the decoder tells them apart
    assign stop_any = stop_instr_i || low_power_stop_instr_i;
    // no-op only starts once the pipe has drained
    assign nop_go_o = nop_instr_i && pipe_idle_i;

    // bus request: stopped and halted issue nothing
    assign bus_req_o = (state == `PSF_ST_RST_SP) || (state == `PSF_ST_RST_PC)
                    || (state == `PSF_ST_EXC_PUSH) || (state == `PSF_ST_EXC_VEC)
                    || ((state == `PSF_ST_NORMAL || state == `PSF_ST_EXC_FILL)
                        && core_req_i);

    always @* begin
        next_state = state;
        case (state)
            `PSF_ST_RST_SP: begin
                if (bus_ack_i) begin
                    next_state = `PSF_ST_RST_PC;
                end
            end
            `PSF_ST_RST_PC: begin
                if (bus_ack_i) begin
                    next_state = `PSF_ST_NORMAL;
                end
            end
            `PSF_ST_NORMAL: begin
                if (exc_any) begin
                    next_state = `PSF_ST_EXC_PUSH;
                end else if (stop_any && sup_eff) begin
                    next_state = `PSF_ST_STOPPED;
                end else if (priv_instr && !sup_eff) begin
                    next_state = `PSF_ST_EXC_PUSH;
                end
            end
            `PSF_ST_STOPPED: begin
                if (exc_trace_i || exc_irq_i) begin
                    next_state = `PSF_ST_EXC_PUSH;
                end
            end
            `PSF_ST_EXC_PUSH: begin
                if (bus_fault) begin
                    next_state = `PSF_ST_HALTED;
                end else if (bus_ack_i) begin
                    next_state = `PSF_ST_EXC_VEC;
                end
            end
            `PSF_ST_EXC_VEC: begin
                if (bus_fault) begin
                    next_state = `PSF_ST_HALTED;
                end else if (bus_ack_i) begin
                    next_state = `PSF_ST_EXC_FILL;
                end
            end
            `PSF_ST_EXC_FILL: begin
                if (bus_fault) begin
                    next_state = `PSF_ST_HALTED;
                end else if (fill_done_i) begin
                    next_state = `PSF_ST_NORMAL;
                end
            end
            `PSF_ST_HALTED: begin
                // only reset_i leaves, so a double fault cannot loop on the bus
                next_state = `PSF_ST_HALTED;
            end
            default: begin
                next_state = `PSF_ST_HALTED;
            end
        endcase
    end

    // state, status word and program counter
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            state        <= `PSF_ST_RST_SP;
            status_word  <= `PSF_SW_RESET;
            saved_status <= 16'h0000;
            pc           <= 32'h00000000;
            priv_viol_o  <= 1'b0;
            flush_o      <= 1'b0;
            full_restore_o <= 1'b0;
        end else begin
            state          <= next_state;
            priv_viol_o    <= 1'b0;
            flush_o        <= 1'b0;
            full_restore_o <= 1'b0;
            case (state)
                `PSF_ST_RST_PC: begin
                    if (bus_ack_i) begin
                        pc      <= bus_rdata_i;
                        flush_o <= 1'b1;
                    end
                end
                `PSF_ST_NORMAL: begin
                    if (next_state == `PSF_ST_EXC_PUSH) begin
                        saved_status <= status_word;
                        priv_viol_o  <= priv_instr && !sup_eff
                                     && !exc_any;
                    end else if (stop_any && sup_eff) begin
                        status_word <= status_word_wdata_i;
                    end else if (status_word_wr_i && sup_eff) begin
                        status_word <= status_word_wdata_i;
                        flush_o     <= 1'b1;
                    end else if (return_from_exception_i && sup_eff) begin
                        // restored flag decides the privilege on resume
                        status_word    <= rte_status_i;
                        pc             <= rte_pc_i;
                        flush_o        <= 1'b1;
                        full_restore_o <= rte_long_frame_i;
                    end
                end
                `PSF_ST_STOPPED: begin
                    if (next_state == `PSF_ST_EXC_PUSH) begin
                        saved_status <= status_word;
                    end
                end
                `PSF_ST_EXC_PUSH: begin
                    // the flag is set only after the old word is on the stack
                    // a fault outranks the ack, so a failed push never raises it
                    if (bus_ack_i && !bus_fault) begin
                        status_word[`PSF_SW_S_BIT] <= 1'b1;
                    end
                end
                `PSF_ST_EXC_VEC: begin
                    if (bus_ack_i && !bus_fault) begin
                        pc      <= bus_rdata_i;
                        flush_o <= 1'b1;
                    end
                end
                default: begin
                    pc <= pc;
                end
            endcase
        end
    end

    // stack pointers: reset loads the supervisor one
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            user_stack_pointer <= 32'h00000000;
            sup_stack_pointer  <= 32'h00000000;
        end else if (state == `PSF_ST_RST_SP && bus_ack_i) begin
            sup_stack_pointer <= bus_rdata_i;
        end else if (state == `PSF_ST_EXC_PUSH && bus_ack_i) begin
            // limitation: only the status word is stacked here, the core stacks the rest
            sup_stack_pointer <= sup_stack_pointer - 32'h00000002;
        end else if (sp_wr_i) begin
            if (sup_eff) begin
                sup_stack_pointer <= sp_wdata_i;
            end else begin
                user_stack_pointer <= sp_wdata_i;
            end
        end
    end

    // registered bus address, data and space code for the next cycle
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            space_code_lines_o <= `PSF_FC_SUP_PROG;
            bus_addr_o         <= `PSF_RST_SP_ADDR;
            bus_wdata_o        <= 32'h00000000;
            bus_write_o        <= 1'b0;
        end else begin
            bus_write_o <= 1'b0;
            bus_wdata_o <= 32'h00000000;
            case (next_state)
                `PSF_ST_RST_SP: begin
                    space_code_lines_o <= space_code(1'b1, 1'b1, 1'b0);
                    bus_addr_o         <= `PSF_RST_SP_ADDR;
                end
                `PSF_ST_RST_PC: begin
                    space_code_lines_o <= space_code(1'b1, 1'b1, 1'b0);
                    bus_addr_o         <= `PSF_RST_PC_ADDR;
                end
                `PSF_ST_EXC_PUSH: begin
                    // push uses the supervisor stack whatever the level was
                    space_code_lines_o <= space_code(1'b1, 1'b0, 1'b0);
                    bus_addr_o         <= sup_stack_pointer - 32'h00000002;
                    bus_wdata_o        <= {16'h0000, (state == `PSF_ST_EXC_PUSH)
                                           ? saved_status : status_word};
                    bus_write_o        <= 1'b1;
                end
                `PSF_ST_EXC_VEC: begin
                    space_code_lines_o <= space_code(1'b1, 1'b0, 1'b0);
                    bus_addr_o         <= exc_vec_addr_i;
                end
                default: begin
                    space_code_lines_o <= space_code(next_state == `PSF_ST_EXC_FILL
                                          || status_word[`PSF_SW_S_BIT],
                                          core_prog_i, core_cpu_i);
                    // special cycles clear unused address bits so decoders see zeros
                    if (core_cpu_i) begin
                        bus_addr_o <= 32'h00000000;
                        bus_addr_o[`PSF_CTYPE_MSB:`PSF_CTYPE_LSB] <= core_ctype_i;
                        bus_addr_o[`PSF_LEVEL_MSB:`PSF_LEVEL_LSB] <= core_level_i;
                    end else begin
                        bus_addr_o <= core_addr_i;
                    end
                end
            endcase
        end
    end

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            proc_state_o  <= `PSF_ST_RST_SP;
            status_word_o <= `PSF_SW_RESET;
            pc_o          <= 32'h00000000;
        end else begin
            proc_state_o  <= next_state;
            status_word_o <= status_word;
            pc_o          <= pc;
        end
    end

endmodule
`default_nettype wire

// *** test/psf_bus_model.sv ***
// bus memory model answering the block's requests after a chosen delay
`timescale 1ns/10ps
`default_nettype none
module psf_bus_model #(
    parameter logic [31:0] SP_INIT = 32'h00001000,
    parameter logic [31:0] PC_INIT = 32'h00000400
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    // request side
    input  wire logic        bus_req_i,
    input  wire logic [31:0] bus_addr_i,
    input  wire logic [2:0]  delay_i,
    // answer side
    output var  logic        bus_ack_o,
    output var  logic [31:0] bus_rdata_o
);
    logic [2:0] wait_cnt;
    // data toggles outside an answer so a stale sample cannot pass
    always @(posedge ref_clk_i) begin
        bus_ack_o   <= 1'b0;
        bus_rdata_o <= ~bus_rdata_o;
        if (reset_i || bus_ack_o) begin
            wait_cnt    <= 3'h0;
            bus_rdata_o <= reset_i ? 32'h5A5A5A5A : ~bus_rdata_o;
        end else if (bus_req_i && wait_cnt >= delay_i) begin
            bus_ack_o   <= 1'b1;
            bus_rdata_o <= (bus_addr_i == 32'h0) ? SP_INIT :
                           (bus_addr_i == 32'h4) ? PC_INIT : bus_addr_i ^ 32'h00008000;
        end else if (bus_req_i) begin
            wait_cnt <= wait_cnt + 3'h1;
        end
    end
endmodule
`default_nettype wire

// *** test/psf_ctrl_sva.sv ***
// assertion checker for the state, privilege and space code block
`timescale 1ns/10ps
`default_nettype none
`include "psf_defs.vh"
module psf_ctrl_sva (
    // clock, reset and events
    input wire logic        ref_clk_i,
    input wire logic        reset_i,
    input wire logic        stop_instr_i,
    input wire logic        low_power_stop_instr_i,
    input wire logic        reset_instr_i,
    input wire logic        status_word_wr_i,
    input wire logic        return_from_exception_i,
    input wire logic        rte_long_frame_i,
    input wire logic        exc_req_i,
    input wire logic        exc_trace_i,
    input wire logic        exc_irq_i,
    input wire logic        bus_err_i,
    input wire logic        addr_err_i,
    input wire logic        core_req_i,
    input wire logic        core_prog_i,
    input wire logic        core_cpu_i,
    // outputs
    input wire logic        bus_req_o,
    input wire logic [2:0]  space_code_lines_o,
    input wire logic [31:0] bus_addr_o,
    input wire logic [31:0] bus_wdata_o,
    input wire logic        bus_write_o,
    input wire logic [2:0]  proc_state_o,
    input wire logic        supervisor_o,
    input wire logic        priv_viol_o,
    input wire logic        flush_o,
    input wire logic        full_restore_o
);
    wire nrm  = proc_state_o == `PSF_ST_NORMAL;
    wire stp  = proc_state_o == `PSF_ST_STOPPED;
    wire hlt  = proc_state_o == `PSF_ST_HALTED;
    wire exc  = proc_state_o[2] && !hlt;
    wire calm = !(exc_req_i | exc_trace_i | exc_irq_i | bus_err_i | addr_err_i);
    wire priv = stop_instr_i | low_power_stop_instr_i | reset_instr_i | status_word_wr_i
                | return_from_exception_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    property p_stop_quiet; stp && !exc_trace_i && !exc_irq_i |-> !bus_req_o ##1 stp; endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("stop left");
    property p_dbl; exc && (bus_err_i || addr_err_i) |=> hlt; endproperty
    a_dbl: assert property (p_dbl) else $error("no halt");
    property p_halt; hlt |-> !bus_req_o ##1 hlt; endproperty
    a_halt: assert property (p_halt) else $error("halt left");
    property p_rst_fetch;
        proc_state_o[2:1] == 2'h0 |-> space_code_lines_o == `PSF_FC_SUP_PROG
            && bus_addr_o == {29'h0, proc_state_o[0], 2'h0};
    endproperty
    a_rst_fetch: assert property (p_rst_fetch) else $error("reset fetch");
    property p_fc_mem;
        nrm && core_req_i && !core_cpu_i && !priv && calm ##1 nrm |-> space_code_lines_o ==
            {$past(supervisor_o), $past(core_prog_i), !$past(core_prog_i)};
    endproperty
    a_fc_mem: assert property (p_fc_mem) else $error("space code");
    property p_priv; nrm && !supervisor_o && calm && priv |=> priv_viol_o && exc; endproperty
    a_priv: assert property (p_priv) else $error("no violation");
    property p_exc_super;
        nrm && !supervisor_o && exc_req_i && !priv |=> supervisor_o && bus_write_o
            && !bus_wdata_o[`PSF_SW_S_BIT] && space_code_lines_o == `PSF_FC_SUP_DATA;
    endproperty
    a_exc_super: assert property (p_exc_super) else $error("entry");
    property p_flush;
        nrm && supervisor_o && calm && (status_word_wr_i || return_from_exception_i)
            |=> flush_o && full_restore_o == $past(return_from_exception_i && rte_long_frame_i);
    endproperty
    a_flush: assert property (p_flush) else $error("flush");
    c_stop: cover property (stp);
    c_halt: cover property (hlt);
    c_viol: cover property (priv_viol_o);
endmodule
bind psf_ctrl psf_ctrl_sva u_sva (.*);
`default_nettype wire

// *** test/tb_psf_ctrl.sv ***
// self-checking bench for the state, privilege and space code block
`timescale 1ns/10ps
`default_nettype none
`include "psf_defs.vh"
module tb_psf_ctrl;
    localparam logic [31:0] SP_INIT = 32'h00001000;
    localparam logic [31:0] PC_INIT = 32'h00000400;
    // stimulus
    logic        ref_clk_i = 1'b0, reset_i = 1'b1, stop_instr_i = 1'b0;
    logic        low_power_stop_instr_i = 1'b0, reset_instr_i = 1'b0, status_word_wr_i = 1'b0;
    logic        return_from_exception_i = 1'b0, rte_long_frame_i = 1'b0, nop_instr_i = 1'b0;
    logic        pipe_idle_i = 1'b1, exc_req_i = 1'b0, exc_trace_i = 1'b0, exc_irq_i = 1'b0;
    logic        fill_done_i = 1'b0, bus_err_i = 1'b0, addr_err_i = 1'b0, sp_wr_i = 1'b0;
    logic        core_req_i = 1'b0, core_prog_i = 1'b0, core_cpu_i = 1'b0;
    logic [3:0]  core_ctype_i = 4'h0, core_level_i = 4'h0;
    logic [15:0] status_word_wdata_i = 16'h0, rte_status_i = 16'h0;
    logic [31:0] rte_pc_i = 32'h0, exc_vec_addr_i = 32'h20, core_addr_i = 32'h0, sp_wdata_i = 32'h0;
    logic [2:0]  delay_i = 3'h0;
    // observed
    logic        bus_ack_i, bus_req_o, bus_write_o, supervisor_o, priv_viol_o, flush_o;
    logic        full_restore_o, nop_go_o;
    logic [2:0]  space_code_lines_o, proc_state_o;
    logic [15:0] status_word_o;
    logic [31:0] bus_rdata_i, bus_addr_o, bus_wdata_o, pc_o, address_reg_seven_o;
    int          fail_count = 0, n_compared = 0, seed = 32'hCE39F6F8, i, k;
    logic [31:0] r, ssp = SP_INIT;

    always #50 ref_clk_i = ~ref_clk_i;
    psf_ctrl DUT (.*);
    psf_bus_model #(.SP_INIT(SP_INIT), .PC_INIT(PC_INIT)) u_mem (.ref_clk_i, .reset_i,
        .bus_req_i(bus_req_o), .bus_addr_i(bus_addr_o), .delay_i, .bus_ack_o(bus_ack_i),
        .bus_rdata_o(bus_rdata_i));

    // the far side answers at a new random pace every cycle
    task automatic step(input int n);
        repeat (n) begin
            @(negedge ref_clk_i);
            delay_i = 3'($random(seed));
        end
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic to_state(input logic [2:0] s);
        for (int j = 0; j < 60 && proc_state_o !== s; j++) step(1);
        chk("state", s, proc_state_o);
    endtask
    // 0 return, 1 status write, 2 stop, 3 low power stop, 4 reset instruction
    task automatic fire(input int n);
        {reset_instr_i, low_power_stop_instr_i, stop_instr_i, status_word_wr_i,
            return_from_exception_i} = 5'h1 << n;
        step(1);
        {reset_instr_i, low_power_stop_instr_i, stop_instr_i, status_word_wr_i,
            return_from_exception_i} = 5'h0;
    endtask
    task automatic finish_exc;
        to_state(`PSF_ST_EXC_FILL);
        fill_done_i = 1'b1;
        step(1);
        fill_done_i = 1'b0;
        chk("handler", `PSF_ST_NORMAL, proc_state_o);
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        fail_count++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        step(12);
        reset_i = 1'b0;
        to_state(`PSF_ST_NORMAL);
        step(2);
        chk("pc", PC_INIT, pc_o);
        chk("a7", SP_INIT, address_reg_seven_o);
        $display("test reset done");
        for (i = 0; i < 24; i++) begin
            if (i == 12) begin
                fire(1);
                chk("flush", 1, flush_o);
                r = $random(seed);
                sp_wdata_i = r;
                sp_wr_i = 1'b1;
                step(1);
                sp_wr_i = 1'b0;
                chk("usp", r, address_reg_seven_o);
            end
            r = $random(seed);
            {core_prog_i, core_ctype_i, core_level_i, core_addr_i} = {r[0], r[7:4], r[11:8], r};
            core_cpu_i = i % 4 == 3;
            if (i % 8 == 3) core_ctype_i = 4'hF;
            core_req_i = 1'b1;
            step(3);
            chk("fc", core_cpu_i ? `PSF_FC_CPU : {i < 12, r[0], !r[0]}, space_code_lines_o);
            if (core_cpu_i) chk("ctype", core_ctype_i, bus_addr_o[19:16]);
            if (core_ctype_i == 4'hF && core_cpu_i) chk("lvl", core_level_i, bus_addr_o[4:1]);
            core_req_i = 1'b0;
            step(1);
        end
        $display("test space codes done");
        for (k = 0; k < 5; k++) begin
            fire(k);
            ssp = ssp - 32'h2;
            chk("viol", 1, priv_viol_o);
            chk("push", ssp, bus_addr_o);
            chk("fc", `PSF_FC_SUP_DATA, space_code_lines_o);
            chk("sold", 0, bus_wdata_o[`PSF_SW_S_BIT]);
            finish_exc();
            chk("ssp", ssp, address_reg_seven_o);
            if (k < 4) fire(1);
            step(1);
        end
        $display("test privilege done");
        for (k = 0; k < 2; k++) begin
            status_word_wdata_i = 16'h2700;
            fire(2 + k);
            chk("stop", `PSF_ST_STOPPED, proc_state_o);
            fire(2);
            chk("sw", 16'h2700, status_word_o);
            r = $random(seed);
            step(r[2:0]);
            chk("stop", `PSF_ST_STOPPED, proc_state_o);
            chk("req", 0, bus_req_o);
            {exc_req_i, exc_trace_i, exc_irq_i} = k ? 3'h5 : 3'h6;
            step(1);
            {exc_req_i, exc_trace_i, exc_irq_i} = 3'h0;
            chk("wake", `PSF_ST_EXC_PUSH, proc_state_o);
            finish_exc();
        end
        $display("test stop done");
        for (k = 0; k < 2; k++) begin
            r = $random(seed);
            rte_pc_i = {r[31:1], 1'b0};
            rte_status_i = k ? 16'h0000 : 16'h2000;
            rte_long_frame_i = !k;
            fire(0);
            chk("flush", 1, flush_o);
            chk("full", !k, full_restore_o);
            step(1);
            chk("sup", !k, supervisor_o);
            if (k) chk("pc", rte_pc_i, pc_o);
        end
        nop_instr_i = 1'b1;
        pipe_idle_i = 1'b0;
        step(3);
        chk("nop", 0, nop_go_o);
        pipe_idle_i = 1'b1;
        step(1);
        chk("nop", 1, nop_go_o);
        nop_instr_i = 1'b0;
        $display("test return and sync done");
        for (k = 0; k < 2; k++) begin
            exc_req_i = 1'b1;
            step(1);
            exc_req_i = 1'b0;
            to_state(k ? `PSF_ST_EXC_FILL : `PSF_ST_EXC_VEC);
            {bus_err_i, addr_err_i} = k ? 2'h1 : 2'h2;
            step(1);
            {bus_err_i, addr_err_i} = 2'h0;
            chk("halt", `PSF_ST_HALTED, proc_state_o);
            exc_irq_i = 1'b1;
            fire(2);
            exc_irq_i = 1'b0;
            step(6);
            chk("halt", `PSF_ST_HALTED, proc_state_o);
            chk("req", 0, bus_req_o);
            reset_i = 1'b1;
            step(2);
            reset_i = 1'b0;
            to_state(`PSF_ST_NORMAL);
        end
        $display("test double fault done");
        report_and_stop();
    end
endmodule
`default_nettype wire
